//--- rtl/sdram_addr_mux_x16.sv
// x16 sdram address multiplexer with apb configuration and burst sequencing
//
// Overview of operation
// - 12row/10col row cycle drives A27..A10
// - 12/10 bank bits on A14,A13; column identity
// - 12/10 geometry: 4-bank device, A17..A15,A0 unused
// - 13row/9col row cycle drives A26..A9
// - 13/9 bank bits on A15,A14; column identity
// - 13/9 geometry: 4-bank device, A17,A16,A0 unused
// - column cycle pin A11 carries command flag
// - flag level set by beat position only: high on the last beat, for reads and writes alike
// - single beats, last auto-precharges, then wait
`timescale 1ns/100ps
`default_nettype none
`include "sdram_mux_params.svh"
module sdram_addr_mux_x16
   import sdram_mux_pkg::*;
#(
   parameter int TRP_CYC = `SDM_TRP_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [27:0] req_addr,
   input  wire logic [3:0]  req_beats,
   output logic             req_ready,
   output logic             busy,
   output logic [17:0]      sdram_addr,
   output logic             row_strobe,
   output logic             col_strobe,
   output logic             autoprecharge,
   output logic             read_with_autoprecharge
);
   function automatic geo_t geo_decode(input logic [31:0] cfg);
      logic [1:0] bsz;
      logic [1:0] row;
      logic [1:0] col;
      bsz = cfg[`SDM_CFG_BSZ_LSB +: 2];
      row = cfg[`SDM_CFG_ROW_LSB +: 2];
      col = cfg[`SDM_CFG_COL_LSB +: 2];
      geo_decode = GEO_NONE;
      if (bsz == `SDM_BSZ_16 && row == `SDM_ROW_12 && col == `SDM_COL_10) begin
         geo_decode = GEO_R12C10;
      end else if (bsz == `SDM_BSZ_16 && row == `SDM_ROW_13 && col == `SDM_COL_9) begin
         geo_decode = GEO_R13C9;
      end
   endfunction

   function automatic logic [17:0] row_map(input logic [27:0] a, input geo_t g);
      row_map = (g == GEO_R13C9) ? a[26:9] : a[27:10];
   endfunction

   function automatic logic [17:0] col_map(input logic [27:0] a, input geo_t g,
                                            input logic flag);
      col_map = a[17:0];
      if (g == GEO_R13C9) begin
         col_map[15] = a[24];
         col_map[14] = a[23];
      end else begin
         col_map[14] = a[24];
         col_map[13] = a[23];
      end
      col_map[11] = flag;
   endfunction

   logic [31:0] cfg_reg, cfg_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic        ready_reg, ready_next;
   logic        busy_reg, busy_next;
   logic [27:0] lat_addr_reg, lat_addr_next;
   logic        lat_write_reg, lat_write_next;
   geo_t        lat_geo_reg, lat_geo_next;
   logic [17:0] pins_reg, pins_next;
   logic [27:0] col_addr_reg, col_addr_next;
   logic        row_stb_reg, row_stb_next;
   logic        col_stb_reg, col_stb_next;
   logic        ap_reg, ap_next;
   logic        rda_reg, rda_next;
   geo_t        geo_cfg;
   logic        start;
   logic        row_go;
   logic        col_go;
   logic        col_last;
   logic [3:0]  beat_idx;
   logic        seq_busy;
   logic        setup;
   logic        access;
   logic        hit_cfg;
   logic        hit_stat;
   logic [27:0] beat_addr;

   assign geo_cfg   = geo_decode(cfg_reg);
   assign start     = req_valid && ready_reg;
   assign setup     = psel && !penable;
   assign access    = psel && penable && pready_reg;
   assign hit_cfg   = (paddr == `SDM_OFS_CFG);
   assign hit_stat  = (paddr == `SDM_OFS_STATUS);
   // 16-bit bus: consecutive beats step the byte address by two
   assign beat_addr = lat_addr_reg + {23'h0, beat_idx, 1'b0};

   sdram_burst_seq #(
      .TRP_CYC (TRP_CYC)
   ) u_seq (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (start),
      .beats    (req_beats),
      .row_go   (row_go),
      .col_go   (col_go),
      .col_last (col_last),
      .beat_idx (beat_idx),
      .busy     (seq_busy)
   );

   // apb slave, one wait-free access phase
   always_comb begin
      cfg_next     = cfg_reg;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      pready_next  = setup;
      if (setup) begin
         prdata_next = 32'h0000_0000;
         if (!pwrite && hit_cfg) begin
            prdata_next = cfg_reg;
         end else if (!pwrite && hit_stat) begin
            prdata_next[`SDM_STAT_BUSY]           = busy_reg;
            prdata_next[`SDM_STAT_GEO_OK]         = (geo_cfg != GEO_NONE);
            prdata_next[`SDM_STAT_PIN_LSB +: 18]  = pins_reg;
         end
         pslverr_next = !(hit_cfg || hit_stat) || (pwrite && hit_stat);
      end
      // geometry changes mid-burst are harmless: the burst uses its latched copy
      if (access && pwrite && hit_cfg) begin
         cfg_next = {26'h0, pwdata[5:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg     <= `SDM_CFG_RST;
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         cfg_reg     <= cfg_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // request capture and pin drive
   always_comb begin
      // decode the value being written so a refused geometry closes the port at once
      ready_next     = !seq_busy && !start && (geo_decode(cfg_next) != GEO_NONE);
      busy_next      = seq_busy || start;
      lat_addr_next  = lat_addr_reg;
      lat_write_next = lat_write_reg;
      lat_geo_next   = lat_geo_reg;
      pins_next      = pins_reg;
      col_addr_next  = col_addr_reg;
      row_stb_next   = 1'b0;
      col_stb_next   = 1'b0;
      ap_next        = ap_reg;
      rda_next       = 1'b0;
      if (start) begin
         lat_addr_next  = req_addr;
         lat_write_next = req_write;
         lat_geo_next   = geo_cfg;
      end
      if (row_go) begin
         pins_next    = row_map(lat_addr_reg, lat_geo_reg);
         row_stb_next = 1'b1;
      end else if (col_go) begin
         // flag follows only the beat position: precharge on the last beat
         ap_next       = col_last;
         pins_next     = col_map(beat_addr, lat_geo_reg, col_last);
         col_addr_next = beat_addr;
         col_stb_next  = 1'b1;
         rda_next      = col_last && !lat_write_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_reg     <= 1'b0;
         busy_reg      <= 1'b0;
         lat_addr_reg  <= 28'h0000000;
         lat_write_reg <= 1'b0;
         lat_geo_reg   <= GEO_NONE;
         pins_reg      <= 18'h00000;
         col_addr_reg  <= 28'h0000000;
         row_stb_reg   <= 1'b0;
         col_stb_reg   <= 1'b0;
         ap_reg        <= 1'b0;
         rda_reg       <= 1'b0;
      end else begin
         ready_reg     <= ready_next;
         busy_reg      <= busy_next;
         lat_addr_reg  <= lat_addr_next;
         lat_write_reg <= lat_write_next;
         lat_geo_reg   <= lat_geo_next;
         pins_reg      <= pins_next;
         col_addr_reg  <= col_addr_next;
         row_stb_reg   <= row_stb_next;
         col_stb_reg   <= col_stb_next;
         ap_reg        <= ap_next;
         rda_reg       <= rda_next;
      end
   end

   assign prdata                  = prdata_reg;
   assign pready                  = pready_reg;
   assign pslverr                 = pslverr_reg;
   assign req_ready               = ready_reg;
   assign busy                    = busy_reg;
   assign sdram_addr              = pins_reg;
   assign row_strobe              = row_stb_reg;
   assign col_strobe              = col_stb_reg;
   assign autoprecharge           = ap_reg;
   assign read_with_autoprecharge = rda_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start_a;
      start && geo_cfg == GEO_R12C10;
   endsequence
   sequence s_start_b;
      start && geo_cfg == GEO_R13C9;
   endsequence
   sequence s_last_col;
      col_stb_reg && ap_reg;
   endsequence

   chk_row_map_a: assert property (
      row_stb_reg && lat_geo_reg == GEO_R12C10 |-> pins_reg == lat_addr_reg[27:10])
      else $error("row cycle pins wrong for 12/10");
   chk_bank_col_a: assert property (
      col_stb_reg && lat_geo_reg == GEO_R12C10 |->
      pins_reg[14] == col_addr_reg[24] && pins_reg[13] == col_addr_reg[23] &&
      pins_reg[10:0] == col_addr_reg[10:0] && pins_reg[17:15] == col_addr_reg[17:15])
      else $error("column pins wrong for 12/10");
   chk_geo_a_row: assert property (
      s_start_a |-> ##2 row_stb_reg && lat_geo_reg == GEO_R12C10)
      else $error("12/10 request gave no row cycle");
   chk_row_map_b: assert property (
      row_stb_reg && lat_geo_reg == GEO_R13C9 |-> pins_reg == lat_addr_reg[26:9])
      else $error("row cycle pins wrong for 13/9");
   chk_bank_col_b: assert property (
      col_stb_reg && lat_geo_reg == GEO_R13C9 |->
      pins_reg[15] == col_addr_reg[24] && pins_reg[14] == col_addr_reg[23] &&
      pins_reg[13:12] == col_addr_reg[13:12] && pins_reg[10:0] == col_addr_reg[10:0])
      else $error("column pins wrong for 13/9");
   chk_geo_b_row: assert property (
      s_start_b |-> ##2 row_stb_reg ##1 col_stb_reg)
      else $error("13/9 request gave no row then column");
   chk_flag_pin: assert property (
      col_stb_reg |-> pins_reg[11] == ap_reg)
      else $error("pin A11 does not carry the command flag");
   chk_flag_kind: assert property (
      read_with_autoprecharge |-> s_last_col and !lat_write_reg)
      else $error("read auto-precharge without last read beat");
   chk_precharge_gap: assert property (
      s_last_col |=> (!col_stb_reg && !row_stb_reg && busy_reg) [*2])
      else $error("precharge wait cut short");
   chk_pin_hold: assert property (
      !row_stb_reg && !col_stb_reg |-> $stable(pins_reg))
      else $error("pins changed outside a cycle start");
endmodule // sdram_addr_mux_x16
`default_nettype wire

//--- rtl/sdram_burst_seq.sv
// sequencer: row cycle, single-beat column cycles, precharge wait
`timescale 1ns/100ps
`default_nettype none
`include "sdram_mux_params.svh"
module sdram_burst_seq
   import sdram_mux_pkg::*;
#(
   parameter int TRP_CYC = `SDM_TRP_CYC
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic [3:0] beats,
   output logic            row_go,
   output logic            col_go,
   output logic            col_last,
   output logic [3:0]      beat_idx,
   output logic            busy
);
   seq_state_t state_reg, state_next;
   logic [3:0] beat_reg, beat_next;
   logic [3:0] last_reg, last_next;
   logic [3:0] wait_reg, wait_next;

   always_comb begin
      state_next = state_reg;
      beat_next  = beat_reg;
      last_next  = last_reg;
      wait_next  = wait_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = ST_ROW;
               beat_next  = 4'h0;
               // zero beats is taken as one
               last_next  = (beats == 4'h0) ? 4'h0 : beats - 4'h1;
            end
         end
         ST_ROW: state_next = ST_COL;
         ST_COL: begin
            // each beat is its own column command, burst length one
            if (beat_reg == last_reg) begin
               state_next = ST_PRE;
               wait_next  = 4'h1;
            end else begin
               beat_next = beat_reg + 4'h1;
            end
         end
         ST_PRE: begin
            if (wait_reg >= 4'(TRP_CYC)) begin
               state_next = ST_IDLE;
            end else begin
               wait_next = wait_reg + 4'h1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         beat_reg  <= 4'h0;
         last_reg  <= 4'h0;
         wait_reg  <= 4'h0;
      end else begin
         state_reg <= state_next;
         beat_reg  <= beat_next;
         last_reg  <= last_next;
         wait_reg  <= wait_next;
      end
   end

   assign row_go   = (state_reg == ST_ROW);
   assign col_go   = (state_reg == ST_COL);
   assign col_last = col_go && (beat_reg == last_reg);
   assign beat_idx = beat_reg;
   assign busy     = (state_reg != ST_IDLE);
endmodule // sdram_burst_seq
`default_nettype wire

//--- rtl/sdram_mux_params.svh
// constants for the x16 sdram address multiplexer
`ifndef SDRAM_MUX_PARAMS_SVH
`define SDRAM_MUX_PARAMS_SVH
`define SDM_OFS_CFG      8'h00
`define SDM_OFS_STATUS   8'h04
`define SDM_CFG_BSZ_LSB  0
`define SDM_CFG_ROW_LSB  2
`define SDM_CFG_COL_LSB  4
`define SDM_CFG_RST      32'h0000_0026
`define SDM_BSZ_16       2'h2
`define SDM_ROW_12       2'h1
`define SDM_ROW_13       2'h2
`define SDM_COL_10       2'h2
`define SDM_COL_9        2'h1
`define SDM_STAT_BUSY    0
`define SDM_STAT_GEO_OK  1
`define SDM_STAT_PIN_LSB 8
`define SDM_CLK_NS       10
`define SDM_TRP_NS       20
`define SDM_TRP_CYC      ((`SDM_TRP_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`endif

//--- rtl/sdram_mux_pkg.sv
// types for the x16 sdram address multiplexer
package sdram_mux_pkg;
   typedef enum logic [1:0] {GEO_NONE, GEO_R12C10, GEO_R13C9} geo_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ROW, ST_COL, ST_PRE} seq_state_t;
endpackage

//--- tb/sdram_addr_mux_x16_tb.sv
// self-checking bench for the x16 sdram address multiplexer
`timescale 1ns/100ps
`default_nettype none
module sdram_addr_mux_x16_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, geo13;
   logic        req_valid, req_write, req_ready, busy, row_strobe, col_strobe, ap, rwa;
   logic [7:0]  paddr, dev_err;
   logic [31:0] pwdata, prdata, seed, rd;
   logic [27:0] req_addr;
   logic [3:0]  req_beats;
   logic [17:0] sdram_addr, last_pins;
   logic [21:0] notes[$];
   int          bad_count, samples_checked, i, g;

   sdram_addr_mux_x16 #(.TRP_CYC(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_beats(req_beats), .req_ready(req_ready), .busy(busy),
      .sdram_addr(sdram_addr), .row_strobe(row_strobe), .col_strobe(col_strobe),
      .autoprecharge(ap), .read_with_autoprecharge(rwa));
   sdram_dev_model mem (.pclk(pclk), .presetn(presetn), .geo13(geo13),
      .sdram_addr(sdram_addr), .row_strobe(row_strobe), .col_strobe(col_strobe),
      .autoprecharge(ap), .err_cnt(dev_err));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [17:0] col_pins(input logic [27:0] a, input logic f);
      logic [17:0] c;
      c = a[17:0];
      c[geo13 ? 15 : 14] = a[24];
      c[geo13 ? 14 : 13] = a[23];
      c[11] = f;
      return c;
   endfunction
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // expected strobes are queued before the request so the watcher never runs dry
   task automatic access(input logic [27:0] a, input logic [3:0] b, input logic w);
      int n, k, nb;
      nb = (b == 0) ? 1 : b;
      notes.push_back({2'b10, geo13 ? a[26:9] : a[27:10], 2'b00});
      for (k = 0; k < nb; k++) begin
         notes.push_back({2'b01, col_pins(a + 28'(2 * k), k == nb - 1), k == nb - 1,
                          !w && k == nb - 1});
      end
      @(posedge pclk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_beats <= b;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      if (req_ready !== 1'b1) bad_count++;
      seed = lfsr(seed);
      req_valid <= 1'b0;
      req_addr <= seed[27:0];
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (req_ready !== 1'b1 && n < 300);
      if (req_ready !== 1'b1) bad_count++;
   endtask

   always @(posedge pclk) begin
      if (presetn === 1'b1 && (row_strobe === 1'b1 || col_strobe === 1'b1)) begin
         if (notes.size() == 0) check(32'h1, 32'h0);
         else check({row_strobe, col_strobe, sdram_addr, col_strobe & ap, rwa},
                    notes.pop_front());
      end else if (presetn === 1'b1) check(sdram_addr, last_pins);
      last_pins = sdram_addr;
   end
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #300000;
      bad_count++;
      finish_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, req_valid, req_write, geo13} = 7'h00;
      {paddr, pwdata, req_addr, req_beats, last_pins} = '0;
      seed = 32'h0790BDAB;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h26);
      apb(1'b1, 8'h04, 32'hFFFFFFFF);
      check(err, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      for (g = 0; g < 2; g++) begin
         geo13 <= g[0];
         apb(1'b1, 8'h00, g ? 32'h1A : 32'h26);
         apb(1'b0, 8'h04, 32'h0);
         check({30'h0, rd[1:0]}, 32'h2);
         for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            // wrapped address gets one beat: a wrapped burst would switch bank mid-access
            access(i == 2 ? 28'hFFFFFFE : seed[27:0],
                   i == 0 ? 4'h0 : (i == 1 ? 4'hF : (i == 2 ? 4'h1 : seed[31:28])),
                   seed[5]);
         end
      end
      apb(1'b1, 8'h00, 32'h25);
      @(posedge pclk);
      check(req_ready, 1'b0);
      req_valid <= 1'b1;
      repeat (6) @(posedge pclk);
      req_valid <= 1'b0;
      apb(1'b0, 8'h04, 32'h0);
      check({rd[25:8], rd[1:0]}, {sdram_addr, 2'b00});
      check(notes.size(), 0);
      check(dev_err, 8'h00);
      finish_test();
   end
endmodule // sdram_addr_mux_x16_tb
`default_nettype wire

//--- tb/sdram_dev_model.sv
// behavioural sdram device watching the multiplexed address pins
`timescale 1ns/100ps
`default_nettype none
module sdram_dev_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        geo13,
   input  wire logic [17:0] sdram_addr,
   input  wire logic        row_strobe,
   input  wire logic        col_strobe,
   input  wire logic        autoprecharge,
   output logic      [7:0]  err_cnt
);
   logic       open_reg;
   logic [1:0] bank_reg;
   logic [1:0] bank;
   // top pins and A0 go nowhere on the memory side, so only the bank pair and the A11 flag are decoded
   assign bank = geo13 ? sdram_addr[15:14] : sdram_addr[14:13];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_reg <= 1'b0;
         bank_reg <= 2'h0;
         err_cnt <= 8'h00;
      end else if (row_strobe) begin
         if (open_reg) err_cnt <= err_cnt + 8'h01;
         open_reg <= 1'b1;
         bank_reg <= bank;
      end else if (col_strobe) begin
         // a column with no open row or on another bank would corrupt a real part
         if (!open_reg || bank !== bank_reg || sdram_addr[11] !== autoprecharge) begin
            err_cnt <= err_cnt + 8'h01;
         end
         if (autoprecharge) open_reg <= 1'b0;
      end
   end
endmodule // sdram_dev_model
`default_nettype wire
